// [hw/spcs_pkg.sv]
// spcs_pkg: register map, field positions and carrier types for the serial port control block
// assumes: 8-bit register port, one 250 MHz clock domain
package spcs_pkg;
   // -------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------
   localparam logic [11:0] SPCS_RSC_OFS = 12'h11D;
   localparam logic [11:0] SPCS_TSC_OFS = 12'h11E;
   localparam logic [11:0] SPCS_BRC_OFS = 12'h11F;
   // -------------------------------------------------------------
   // transmit status and control fields
   // -------------------------------------------------------------
   localparam int SPCS_T_CLOCK_SOURCE_SELECT = 7;
   localparam int SPCS_T_TX9 = 6;
   localparam int SPCS_T_TRANSMITTER_ENABLE = 5;
   localparam int SPCS_T_SYNC = 4;
   localparam int SPCS_T_BRK = 3;
   localparam int SPCS_T_HS = 2;
   localparam int SPCS_T_EMPTY = 1;
   localparam int SPCS_T_NINTH = 0;
   // -------------------------------------------------------------
   // receive status and control fields
   // -------------------------------------------------------------
   localparam int SPCS_R_PEN = 7;
   localparam int SPCS_R_RX9 = 6;
   localparam int SPCS_R_SINGLE_RECEIVE_ENABLE = 5;
   localparam int SPCS_R_CONTINUOUS_RECEIVE_ENABLE = 4;
   localparam int SPCS_R_ADDR = 3;
   localparam int SPCS_R_FRAMING_ERROR = 2;
   localparam int SPCS_R_OVERRUN_ERROR = 1;
   localparam int SPCS_R_NINTH = 0;
   // -------------------------------------------------------------
   // baud control fields
   // -------------------------------------------------------------
   localparam int SPCS_B_OVF = 7;
   localparam int SPCS_B_IDLE = 6;
   localparam int SPCS_B_POL = 4;
   localparam int SPCS_B_W16 = 3;
   localparam int SPCS_B_WAKE = 1;
   localparam int SPCS_B_ABD = 0;
   // writable masks; bits 5 and 2 of baud control are unimplemented
   localparam logic [7:0] SPCS_TSC_WMASK = 8'hFD;
   localparam logic [7:0] SPCS_RSC_WMASK = 8'hF9;
   localparam logic [7:0] SPCS_BRC_WMASK = 8'h1B;
   localparam logic [7:0] SPCS_TSC_RST = 8'h02;
   // receiver starts idle, so only the idle flag reads high after reset
   localparam logic [7:0] SPCS_BRC_RST = 8'h40;
   localparam logic [7:0] SPCS_ZERO8 = 8'h00;
   localparam logic [2:0] SPCS_DIV_HI = 3'h2;
   localparam logic [2:0] SPCS_DIV_LO = 3'h4;

   // decoded mode handed to the engines
   typedef struct packed {
      logic sync_mode;
      logic host_clock;
      logic tx_nine;
      logic rx_nine;
      logic tx_enable;
      logic rx_enable;
      logic break_pending;
      logic line_invert;
      logic clock_rising;
      logic wide_divider;
      logic [2:0] prescale_log2;
      logic addr_filter;
      logic port_active;
   } spcs_mode_t;

   // events reported by the shift and baud engines
   typedef struct packed {
      logic shifter_busy;
      logic break_done;
      logic rx_start;
      logic rx_done;
      logic rx_ninth;
      logic rx_frame_err;
      logic rx_overrun;
      logic abd_overflow;
      logic abd_done;
      logic wake_edge;
   } spcs_evt_t;

   typedef struct packed {
      logic [7:0] tsc;
      logic [7:0] rsc;
      logic [7:0] brc;
      logic rx_busy;
      logic [7:0] rdata;
   } spcs_state_t;
endpackage

// [hw/spcs_ctrl.sv]
// spcs_ctrl: control and status registers of the serial port
// assumes: engine events arrive on clk_in; software uses a one-cycle strobe port
//
// Contract
// - in sync mode clock source bit picks host clock or external client clock.
// - nine-bit enables select 9-bit or 8-bit transmit and receive widths.
// - mode bit selects synchronous when set, asynchronous when clear.
// - async break request sends break next, hardware clears it when done.
// - async high speed divides by 4 with wide divider, else by 16.
// - shifter empty reads 1 when transmit shifter empty; resets to 1.
// - ninth data bits are held plainly; firmware decides their meaning.
// - in sync mode either receive enable overrides transmit enable.
// - port enable activates port; clearing it holds all logic in reset; here a transmit control write still lands for one cycle.
// - sync host single receive takes one character, then clears itself.
// - continuous receive runs until cleared, beats single; async enables receiver.
// - async 9-bit address detect accepts only characters with ninth bit 1.
// - framing error flag belongs to the unread received character.
// - overrun flag holds until port enable or continuous receive cleared.
// - async auto-baud overflow flag reports timer overflow.
// - async receive idle reads 0 from start bit to character end.
// - async polarity bit gives idle-low inverted transmit line.
// - sync polarity bit picks rising or falling data clock edge.
// - divider width bit selects 16-bit or 8-bit baud generator.
// - async wake-up sets receive flag on falling edge, then clears itself.
// - async auto-baud enable starts detection, hardware clears on completion; here the bit is not passed to the engines in mode_out.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module spcs_ctrl
   import spcs_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // register port
   input wire logic [11:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // engine side
   input wire spcs_evt_t evt_in,
   output spcs_mode_t mode_out,
   output logic rx_accept_out,
   output logic rx_flag_set_out
);
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   spcs_state_t st_reg;
   spcs_state_t st_next;
   spcs_mode_t mode_reg;
   spcs_mode_t mode_next;
   logic accept_reg;
   logic accept_next;
   logic flag_reg;
   logic flag_next;

   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] m);
      merge = (old & ~m) | (wd & m);
   endfunction

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      logic sync;
      logic accept;
      sync = st_reg.tsc[SPCS_T_SYNC];
      st_next = st_reg;
      accept = 1'b0;
      // software writes; hardware sets below win over them
      if (wr_in && hit(addr_in, SPCS_TSC_OFS)) begin
         st_next.tsc = merge(st_reg.tsc, wdata_in, SPCS_TSC_WMASK);
      end
      if (wr_in && hit(addr_in, SPCS_RSC_OFS)) begin
         st_next.rsc = merge(st_reg.rsc, wdata_in, SPCS_RSC_WMASK);
      end
      if (wr_in && hit(addr_in, SPCS_BRC_OFS)) begin
         st_next.brc = merge(st_reg.brc, wdata_in, SPCS_BRC_WMASK);
      end
      st_next.tsc[SPCS_T_EMPTY] = ~evt_in.shifter_busy;
      if (!sync && evt_in.break_done) begin
         st_next.tsc[SPCS_T_BRK] = 1'b0;
      end
      if (sync && st_reg.tsc[SPCS_T_CLOCK_SOURCE_SELECT] && evt_in.rx_done) begin
         st_next.rsc[SPCS_R_SINGLE_RECEIVE_ENABLE] = 1'b0;
      end
      if (evt_in.rx_start) begin
         st_next.rx_busy = 1'b1;
      end
      if (evt_in.rx_done) begin
         st_next.rx_busy = 1'b0;
         // address filter only in async nine-bit
         accept = sync || !st_reg.rsc[SPCS_R_RX9] || !st_reg.rsc[SPCS_R_ADDR] || evt_in.rx_ninth;
         if (accept) begin
            st_next.rsc[SPCS_R_NINTH] = evt_in.rx_ninth;
            st_next.rsc[SPCS_R_FRAMING_ERROR] = evt_in.rx_frame_err;
         end
      end
      if (!st_next.rsc[SPCS_R_CONTINUOUS_RECEIVE_ENABLE]) begin
         st_next.rsc[SPCS_R_OVERRUN_ERROR] = 1'b0;
      end
      if (evt_in.rx_overrun) begin
         st_next.rsc[SPCS_R_OVERRUN_ERROR] = 1'b1;
      end
      if (!sync && evt_in.abd_overflow) begin
         st_next.brc[SPCS_B_OVF] = 1'b1;
      end
      if (!sync && evt_in.abd_done) begin
         st_next.brc[SPCS_B_ABD] = 1'b0;
      end
      if (!sync && st_reg.brc[SPCS_B_WAKE] && evt_in.wake_edge) begin
         st_next.brc[SPCS_B_WAKE] = 1'b0;
      end
      st_next.brc[SPCS_B_IDLE] = ~st_next.rx_busy;
      // read data, one cycle later
      st_next.rdata = SPCS_ZERO8;
      if (rd_in) begin
         if (hit(addr_in, SPCS_TSC_OFS)) begin
            st_next.rdata = st_reg.tsc;
         end else if (hit(addr_in, SPCS_RSC_OFS)) begin
            st_next.rdata = st_reg.rsc;
         end else if (hit(addr_in, SPCS_BRC_OFS)) begin
            st_next.rdata = st_reg.brc;
         end
      end
      accept_next = accept;
      flag_next = accept || (!sync && st_reg.brc[SPCS_B_WAKE] && evt_in.wake_edge);
      // mode decode
      mode_next.sync_mode = sync;
      mode_next.host_clock = sync && st_reg.tsc[SPCS_T_CLOCK_SOURCE_SELECT];
      mode_next.tx_nine = st_reg.tsc[SPCS_T_TX9];
      mode_next.rx_nine = st_reg.rsc[SPCS_R_RX9];
      mode_next.rx_enable = st_reg.rsc[SPCS_R_CONTINUOUS_RECEIVE_ENABLE] ||
         (sync && st_reg.tsc[SPCS_T_CLOCK_SOURCE_SELECT] && st_reg.rsc[SPCS_R_SINGLE_RECEIVE_ENABLE]);
      mode_next.tx_enable = st_reg.tsc[SPCS_T_TRANSMITTER_ENABLE] &&
         !(sync && (st_reg.rsc[SPCS_R_SINGLE_RECEIVE_ENABLE] || st_reg.rsc[SPCS_R_CONTINUOUS_RECEIVE_ENABLE]));
      mode_next.break_pending = !sync && st_reg.tsc[SPCS_T_BRK];
      mode_next.line_invert = !sync && st_reg.brc[SPCS_B_POL];
      mode_next.clock_rising = sync && st_reg.brc[SPCS_B_POL];
      mode_next.wide_divider = st_reg.brc[SPCS_B_W16];
      mode_next.prescale_log2 = (!sync && st_reg.tsc[SPCS_T_HS] && st_reg.brc[SPCS_B_W16]) ?
         SPCS_DIV_HI : SPCS_DIV_LO;
      mode_next.addr_filter = !sync && st_reg.rsc[SPCS_R_RX9] && st_reg.rsc[SPCS_R_ADDR];
      mode_next.port_active = st_reg.rsc[SPCS_R_PEN];
      // port enable low holds every register but itself and the read data in reset; a transmit control write still lands for one cycle
      if (!st_reg.rsc[SPCS_R_PEN]) begin
         st_next.tsc = SPCS_TSC_RST;
         st_next.rsc = st_next.rsc & (8'h01 << SPCS_R_PEN);
         st_next.brc = SPCS_BRC_RST;
         st_next.rx_busy = 1'b0;
         mode_next = '0;
         accept_next = 1'b0;
         flag_next = 1'b0;
         if (wr_in && hit(addr_in, SPCS_TSC_OFS)) begin
            st_next.tsc = merge(SPCS_TSC_RST, wdata_in, SPCS_TSC_WMASK);
         end
      end
   end

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_reg <= '{tsc: SPCS_TSC_RST, rsc: SPCS_ZERO8, brc: SPCS_BRC_RST, rx_busy: 1'b0, rdata: SPCS_ZERO8};
         mode_reg <= '0;
         accept_reg <= 1'b0;
         flag_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         mode_reg <= mode_next;
         accept_reg <= accept_next;
         flag_reg <= flag_next;
      end
   end

   assign rdata_out = st_reg.rdata;
   assign mode_out = mode_reg;
   assign rx_accept_out = accept_reg;
   assign rx_flag_set_out = flag_reg;
endmodule
`default_nettype wire

// [bench/spcs_engine_model.sv]
// spcs_engine_model: stand-in for the shift and baud engines
// assumes: bench asks for events as one-cycle requests on clk_in
`timescale 1ns/1ps
`default_nettype none
module spcs_engine_model
   import spcs_pkg::*;
(
   // clock
   input wire logic clk_in,
   // bench and block side
   input wire spcs_mode_t mode_in,
   input wire spcs_evt_t req_in,
   output spcs_evt_t evt_out
);
   initial evt_out = '0;
   // no character completes while the receiver is off
   always @(posedge clk_in) begin
      evt_out <= req_in;
      evt_out.rx_done <= req_in.rx_done && mode_in.rx_enable;
   end
endmodule
`default_nettype wire

// [bench/spcs_ctrl_checker.sv]
// spcs_ctrl_checker: port assertions of spcs_ctrl
// assumes: bound to spcs_ctrl, one clock
`timescale 1ns/1ps
`default_nettype none
module spcs_ctrl_checker
   import spcs_pkg::*;
(
   // watched ports
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [11:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] rdata_out,
   input wire spcs_evt_t evt_in,
   input wire spcs_mode_t mode_out,
   input wire logic rx_accept_out,
   input wire logic rx_flag_set_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic mapd;
   assign mapd = addr_in inside {SPCS_RSC_OFS, SPCS_TSC_OFS, SPCS_BRC_OFS};
   a_rdata_quiet: assert property (!rd_in |=> rdata_out == SPCS_ZERO8) else $error("read data off slot");
   a_unmapped_zero: assert property (rd_in && !mapd |=> rdata_out == SPCS_ZERO8) else $error("unmapped read");
   a_baud_gaps: assert property (rd_in && addr_in == SPCS_BRC_OFS |=> !rdata_out[5] && !rdata_out[2])
      else $error("baud gap bits set");
   a_port_off: assert property (wr_in && addr_in == SPCS_RSC_OFS && !wdata_in[7] |=> ##1 !mode_out.port_active)
      else $error("port still active");
   a_div_sel: assert property (mode_out.prescale_log2 == SPCS_DIV_HI |-> !mode_out.sync_mode && mode_out.wide_divider)
      else $error("fast divide in wrong mode");
   a_addr_filter: assert property (evt_in.rx_done && !evt_in.rx_ninth && mode_out.addr_filter && mode_out.rx_nine
      && !mode_out.sync_mode |=> !rx_accept_out) else $error("filtered char accepted");
   a_accept_cause: assert property (rx_accept_out |-> $past(evt_in.rx_done) && rx_flag_set_out)
      else $error("accept without character");
   a_flag_cause: assert property (rx_flag_set_out |-> $past(evt_in.rx_done || evt_in.wake_edge))
      else $error("flag without cause");
   a_break_clear: assert property (evt_in.break_done && !wr_in ##1 !wr_in |=> !mode_out.break_pending)
      else $error("break not cleared");
   a_shift_empty: assert property ((!evt_in.shifter_busy) [*3] ##0 (rd_in && addr_in == SPCS_TSC_OFS)
      |=> rdata_out[SPCS_T_EMPTY]) else $error("shifter empty low");
   c_accept: cover property (rx_accept_out);
   c_host: cover property (mode_out.sync_mode && mode_out.host_clock);
   c_baud_rd: cover property (rd_in && addr_in == SPCS_BRC_OFS);
endmodule
`default_nettype wire

// [bench/spcs_ctrl_tb_top.sv]
// spcs_ctrl_tb_top: self-checking bench of the port registers
// assumes: block, engine model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module spcs_ctrl_tb_top
   import spcs_pkg::*;
;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [11:0] addr_in = '0;
   logic [7:0] wdata_in = '0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] rdata_out;
   logic rx_accept_out;
   logic rx_flag_set_out;
   spcs_evt_t evt_in;
   spcs_evt_t req = '0;
   spcs_mode_t mode_out;
   int n_fail = 0;
   int n_tests = 0;
   int n_acc = 0;
   int n_flg = 0;
   int k;
   logic [7:0] d;
   logic [7:0] b;
   always #2 clk_in = ~clk_in;
   spcs_ctrl i_dut (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .evt_in, .mode_out,
      .rx_accept_out, .rx_flag_set_out);
   spcs_engine_model i_eng (.clk_in, .mode_in(mode_out), .req_in(req), .evt_out(evt_in));
   always @(posedge clk_in) if (rx_accept_out === 1'b1) n_acc++;
   always @(posedge clk_in) if (rx_flag_set_out === 1'b1) n_flg++;
   // ----------
   // helpers
   // ----------
   function automatic logic [7:0] e_brc(input logic [7:0] v);
      return (v & SPCS_BRC_WMASK) | 8'h40;
   endfunction
   function automatic logic [2:0] e_div(input logic [7:0] t, input logic [7:0] v);
      return (!t[4] && t[2] && v[3]) ? 3'h2 : 3'h4;
   endfunction
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input string nm, input logic [11:0] a, input logic [7:0] m, input logic [7:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk(nm, exp & m, rdata_out & m);
   endtask
   task automatic ev(input logic [9:0] v);
      @(posedge clk_in);
      req <= v;
      @(posedge clk_in);
      req <= '0;
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // hang guard, far above the sequence length
   initial begin
      repeat (20000) @(posedge clk_in);
      n_fail++;
      report_and_stop();
   end
   initial begin
      k = $urandom(27);
      repeat (8) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd("tsc", SPCS_TSC_OFS, 8'hFF, SPCS_TSC_RST);
      rd("brc", SPCS_BRC_OFS, 8'hFF, 8'h40);
      rd("none", 12'h11C, 8'hFF, SPCS_ZERO8);
      wr(SPCS_TSC_OFS, 8'hFF);
      rd("tsc off", SPCS_TSC_OFS, 8'hFF, SPCS_TSC_RST);
      wr(SPCS_RSC_OFS, 8'h90);
      for (int i = 0; i < 16; i++) begin
         b = 8'($urandom);
         d = 8'($urandom);
         wr(SPCS_BRC_OFS, b);
         wr(SPCS_TSC_OFS, d);
         rd("brc", SPCS_BRC_OFS, 8'hFF, e_brc(b));
         rd("tsc", SPCS_TSC_OFS, 8'hFF, (d & SPCS_TSC_WMASK) | 8'h02);
         chk("mode", {5'h0, d[6], d[7] & d[4], d[4]}, {5'h0, mode_out.tx_nine, mode_out.host_clock,
            mode_out.sync_mode});
         chk("div", {4'h0, b[3], e_div(d, b)}, {4'h0, mode_out.wide_divider, mode_out.prescale_log2});
         chk("pol", {6'h0, b[4] & ~d[4], b[4] & d[4]}, {6'h0, mode_out.line_invert, mode_out.clock_rising});
         chk("brk", {7'h0, d[3] & ~d[4]}, {7'h0, mode_out.break_pending});
      end
      wr(SPCS_TSC_OFS, 8'h08);
      wr(SPCS_BRC_OFS, 8'h00);
      ev(10'h100);
      rd("break", SPCS_TSC_OFS, 8'h08, 8'h00);
      @(posedge clk_in);
      req <= 10'h200;
      repeat (3) @(posedge clk_in);
      rd("busy", SPCS_TSC_OFS, 8'h02, 8'h00);
      @(posedge clk_in);
      req <= '0;
      ev(10'h008);
      rd("ovr", SPCS_RSC_OFS, 8'h02, 8'h02);
      wr(SPCS_RSC_OFS, 8'h80);
      rd("ovr clr", SPCS_RSC_OFS, 8'h02, 8'h00);
      wr(SPCS_RSC_OFS, 8'h90);
      ev(10'h070);
      rd("framing_error", SPCS_RSC_OFS, 8'h05, 8'h05);
      ev(10'h080);
      rd("busy rx", SPCS_BRC_OFS, 8'h40, 8'h00);
      ev(10'h040);
      rd("idle", SPCS_BRC_OFS, 8'h40, 8'h40);
      wr(SPCS_RSC_OFS, 8'hD8);
      repeat (2) @(posedge clk_in);
      k = n_acc;
      ev(10'h040);
      ev(10'h060);
      repeat (3) @(posedge clk_in);
      chk("accepted", 8'h01, 8'(n_acc - k));
      wr(SPCS_BRC_OFS, 8'h02);
      k = n_flg;
      ev(10'h001);
      rd("wake", SPCS_BRC_OFS, 8'h02, 8'h00);
      chk("wake flag", 8'h01, 8'(n_flg - k));
      wr(SPCS_BRC_OFS, 8'h01);
      ev(10'h006);
      rd("abd", SPCS_BRC_OFS, 8'h81, 8'h80);
      wr(SPCS_TSC_OFS, 8'hB0);
      wr(SPCS_RSC_OFS, 8'hA0);
      rd("single_receive_enable", SPCS_RSC_OFS, 8'h20, 8'h20);
      chk("rx on", 8'h01, {7'h0, mode_out.rx_enable});
      chk("tx off", 8'h00, {7'h0, mode_out.tx_enable});
      ev(10'h040);
      rd("single_receive_enable clr", SPCS_RSC_OFS, 8'h20, 8'h00);
      wr(SPCS_RSC_OFS, 8'h00);
      rd("pen off", SPCS_BRC_OFS, 8'hFF, 8'h40);
      report_and_stop();
   end
endmodule
bind spcs_ctrl spcs_ctrl_checker i_chk (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
   .evt_in, .mode_out, .rx_accept_out, .rx_flag_set_out);
`default_nettype wire
